// ---- rtl/cab_pkg.sv ----
// package: constants, opcodes and command carrier for the execution unit
package cab_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int GPR_NUM = 32;
  localparam int IO_BIT_NUM = 32;
  localparam int PC_W = 16;
  localparam int CNT_W = 2;

  // ----------------------------------------
  // register port map (8-bit address)
  // ----------------------------------------
  localparam logic [7:0] ADR_GPR_BASE = 8'h00;
  localparam logic [7:0] ADR_IO_BASE = 8'h20;
  localparam logic [7:0] ADR_FLAGS = 8'h40;
  localparam logic [7:0] ADR_PC_LO = 8'h41;
  localparam logic [7:0] ADR_PC_HI = 8'h42;
  localparam logic [7:0] ADR_SP = 8'h43;

  // ----------------------------------------
  // flag positions in cpu_flag_register
  // ----------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [7:0] GPR_RST = 8'h00;

  // ----------------------------------------
  // extra cycles beyond the first
  // ----------------------------------------
  localparam logic [CNT_W-1:0] XTRA_NONE = 2'h0;
  localparam logic [CNT_W-1:0] XTRA_WORD = 2'h1;
  localparam logic [CNT_W-1:0] XTRA_JUMP = 2'h1;
  localparam logic [CNT_W-1:0] XTRA_IO_BIT = 2'h1;
  localparam logic [CNT_W-1:0] XTRA_BRANCH = 2'h1;
  localparam logic [CNT_W-1:0] XTRA_SKIP_ONE = 2'h1;
  localparam logic [CNT_W-1:0] XTRA_SKIP_TWO = 2'h2;

  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE,
    OP_SUM,
    OP_SUM_CARRY,
    OP_DIFF,
    OP_DIFFERENCE_IMM,
    OP_DIFFERENCE_WITH_BORROW,
    OP_DIFFERENCE_IMM_BORROW,
    OP_CONJ,
    OP_CONJ_WITH_CONSTANT,
    OP_DISJ,
    OP_DISJ_WITH_CONSTANT,
    OP_EXCLUSIVE_DISJ,
    OP_MASK_SET,
    OP_MASK_CLEAR,
    OP_ZERO_NEG_CHECK,
    OP_WORD_PLUS_IMM,
    OP_WORD_MINUS_IMM,
    OP_POINTER_JUMP,
    OP_POINTER_CALL,
    OP_EQUAL_SKIP,
    OP_IMM_COMPARE,
    OP_SKIP_IF_REG_BIT_LOW,
    OP_SKIP_IF_REG_BIT_HIGH,
    OP_SKIP_IF_IO_BIT_LOW,
    OP_SKIP_IF_IO_BIT_HIGH,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_BRANCH_FLAG_HIGH,
    OP_BRANCH_FLAG_LOW
  } cab_op_t;

  typedef enum logic [3:0] {
    ST_READY = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_PUSH_LO = 4'b0100,
    ST_PUSH_HI = 4'b1000
  } cab_state_t;

  typedef struct packed {
    cab_op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [5:0] io_addr;
    logic [1:0] pair_sel;
    logic [6:0] disp;
    logic next_two_word;
  } cab_cmd_t;

endpackage

// ---- rtl/cab_exec.sv ----
// execution unit: arithmetic, logic, io bit access, skips and branches
//
// Overview of operation
// - bit set, clear and test work only on io addresses 0x00 to 0x1F
// - io bit set or clear changes only the addressed bit
// - byte add, with or without carry, stores sum, sets Z C N V H, 1 cycle
// - word add or subtract immediate updates pair, sets Z C N V S, 2 cycles
// - byte subtract, register or constant, with or without borrow: Z C N V H, 1 cycle
// - and, or with register or constant, xor with register: store, only Z N V, 1 cycle
// - mask clear computes register and (0xFF minus mask), sets Z N V
// - mask set ors constant into register, sets Z N V, 1 cycle
// - zero-negative check ands register with itself, value kept, Z N V, 1 cycle
// - pointer jump loads pc from Z pair, no flags, 2 cycles
// - pointer call pushes return address, loads pc from Z, 3 cycles
// - equal skip skips next instruction on match, pc plus 2 or 3, no flags
// - immediate compare subtracts without storing, sets Z N V C H, 1 cycle
// - register bit skip tests a register bit low or high, skips when true
// - flag branch loads pc plus k plus 1 when true, 1 or 2 cycles
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module cab_exec #(
  parameter int SP_W = 8,
  parameter logic [15:0] SP_RST = 16'hffff
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // instruction issue
  input wire logic cmd_valid,
  input wire cab_pkg::cab_cmd_t cmd,
  output logic cmd_ready,
  output logic exec_done,
  // core state
  output logic [cab_pkg::PC_W-1:0] pc,
  output logic [7:0] cpu_flag_register,
  // stack write port
  output logic stk_we,
  output logic [SP_W-1:0] stk_addr,
  output logic [7:0] stk_data,
  // register port
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata
);
  import cab_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (SP_W < 2 || SP_W > 16) begin : g_bad_sp
    $error("cab_exec: SP_W must be 2..16");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  cab_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PC_W-1:0] pc_q, pc_d, ret_q, ret_d;
  logic [SP_W-1:0] sp_q, sp_d;
  logic [7:0] gpr_q [GPR_NUM], gpr_d [GPR_NUM];
  logic [7:0] io_q [IO_BIT_NUM], io_d [IO_BIT_NUM];
  logic ready_q, ready_d, done_q, done_d, stk_we_q, stk_we_d;
  logic [SP_W-1:0] stk_addr_q, stk_addr_d;
  logic [7:0] flg_q, flg_d, stk_data_q, stk_data_d, rdata_q, rdata_d;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic [7:0] a, b, sb, r;
    logic [8:0] s9;
    logic cin, cond;
    logic [4:0] lo_i, hi_i;
    logic [15:0] a16, r16;
    logic [CNT_W-1:0] xtra;
    a = 8'h00;
    b = 8'h00;
    sb = 8'h00;
    r = 8'h00;
    s9 = 9'h000;
    cin = 1'b0;
    cond = 1'b0;
    lo_i = 5'h00;
    hi_i = 5'h00;
    a16 = 16'h0000;
    r16 = 16'h0000;
    xtra = XTRA_NONE;
    st_d = st_q;
    cnt_d = cnt_q;
    pc_d = pc_q;
    ret_d = ret_q;
    flg_d = flg_q;
    sp_d = sp_q;
    gpr_d = gpr_q;
    io_d = io_q;
    done_d = 1'b0;
    stk_we_d = 1'b0;
    stk_addr_d = stk_addr_q;
    stk_data_d = stk_data_q;
    rdata_d = 8'h00;
    // register port: unmapped reads give zero, unmapped writes are dropped
    if (bus_rd) begin
      if (bus_addr[7:5] == ADR_GPR_BASE[7:5]) begin
        rdata_d = gpr_q[bus_addr[4:0]];
      end else if (bus_addr[7:5] == ADR_IO_BASE[7:5]) begin
        rdata_d = io_q[bus_addr[4:0]];
      end else if (bus_addr == ADR_FLAGS) begin
        rdata_d = flg_q;
      end else if (bus_addr == ADR_PC_LO) begin
        rdata_d = pc_q[7:0];
      end else if (bus_addr == ADR_PC_HI) begin
        rdata_d = pc_q[15:8];
      end else if (bus_addr == ADR_SP) begin
        rdata_d = 8'(sp_q);
      end
    end
    if (bus_wr) begin
      if (bus_addr[7:5] == ADR_GPR_BASE[7:5]) begin
        gpr_d[bus_addr[4:0]] = bus_wdata;
      end else if (bus_addr[7:5] == ADR_IO_BASE[7:5]) begin
        io_d[bus_addr[4:0]] = bus_wdata;
      end else if (bus_addr == ADR_FLAGS) begin
        flg_d = bus_wdata;
      end else if (bus_addr == ADR_SP) begin
        sp_d = SP_W'(bus_wdata);
      end
    end
    // engine; its writes come after the port so the engine wins a clash
    case (st_q)
      ST_READY: begin
        if (cmd_valid) begin
          a = gpr_q[cmd.dst];
          b = gpr_q[cmd.src];
          pc_d = pc_q + 16'h0001;
          case (cmd.op)
            OP_SUM, OP_SUM_CARRY: begin
              cin = (cmd.op == OP_SUM_CARRY) & flg_q[FLG_C];
              s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
              r = s9[7:0];
              gpr_d[cmd.dst] = r;
              flg_d[FLG_H] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
              flg_d[FLG_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
              flg_d[FLG_N] = r[7];
              flg_d[FLG_Z] = (r == 8'h00);
              flg_d[FLG_C] = s9[8];
            end
            OP_DIFF, OP_DIFFERENCE_IMM, OP_DIFFERENCE_WITH_BORROW,
            OP_DIFFERENCE_IMM_BORROW, OP_IMM_COMPARE: begin
              sb = (cmd.op == OP_DIFF || cmd.op == OP_DIFFERENCE_WITH_BORROW) ? b : cmd.imm;
              cin = (cmd.op == OP_DIFFERENCE_WITH_BORROW || cmd.op == OP_DIFFERENCE_IMM_BORROW)
                    & flg_q[FLG_C];
              s9 = {1'b0, a} - {1'b0, sb} - {8'h00, cin};
              r = s9[7:0];
              if (cmd.op != OP_IMM_COMPARE) begin
                gpr_d[cmd.dst] = r;
              end
              flg_d[FLG_H] = (~a[3] & sb[3]) | (sb[3] & r[3]) | (r[3] & ~a[3]);
              flg_d[FLG_V] = (a[7] & ~sb[7] & ~r[7]) | (~a[7] & sb[7] & r[7]);
              flg_d[FLG_N] = r[7];
              flg_d[FLG_C] = (~a[7] & sb[7]) | (sb[7] & r[7]) | (r[7] & ~a[7]);
              // borrow chains keep Z only while every byte is zero
              if (cmd.op inside {OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_IMM_BORROW}) begin
                flg_d[FLG_Z] = (r == 8'h00) & flg_q[FLG_Z];
              end else begin
                flg_d[FLG_Z] = (r == 8'h00);
              end
            end
            OP_CONJ, OP_CONJ_WITH_CONSTANT, OP_DISJ, OP_DISJ_WITH_CONSTANT,
            OP_EXCLUSIVE_DISJ, OP_MASK_SET, OP_MASK_CLEAR, OP_ZERO_NEG_CHECK: begin
              case (cmd.op)
                OP_CONJ: r = a & b;
                OP_CONJ_WITH_CONSTANT: r = a & cmd.imm;
                OP_DISJ: r = a | b;
                OP_DISJ_WITH_CONSTANT: r = a | cmd.imm;
                OP_EXCLUSIVE_DISJ: r = a ^ b;
                OP_MASK_SET: r = a | cmd.imm;
                OP_MASK_CLEAR: r = a & (8'hff - cmd.imm);
                OP_ZERO_NEG_CHECK: r = a & a;
                default: r = a;
              endcase
              gpr_d[cmd.dst] = r;
              flg_d[FLG_V] = 1'b0;
              flg_d[FLG_N] = r[7];
              flg_d[FLG_Z] = (r == 8'h00);
            end
            OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
              lo_i = {2'b11, cmd.pair_sel, 1'b0};
              hi_i = {2'b11, cmd.pair_sel, 1'b1};
              a16 = {gpr_q[hi_i], gpr_q[lo_i]};
              if (cmd.op == OP_WORD_PLUS_IMM) begin
                r16 = a16 + {10'h000, cmd.imm[5:0]};
                flg_d[FLG_V] = ~a16[15] & r16[15];
                flg_d[FLG_C] = ~r16[15] & a16[15];
              end else begin
                r16 = a16 - {10'h000, cmd.imm[5:0]};
                flg_d[FLG_V] = a16[15] & ~r16[15];
                flg_d[FLG_C] = r16[15] & ~a16[15];
              end
              gpr_d[lo_i] = r16[7:0];
              gpr_d[hi_i] = r16[15:8];
              flg_d[FLG_N] = r16[15];
              flg_d[FLG_Z] = (r16 == 16'h0000);
              flg_d[FLG_S] = r16[15] ^ flg_d[FLG_V];
              xtra = XTRA_WORD;
            end
            OP_POINTER_JUMP: begin
              pc_d = {gpr_q[31], gpr_q[30]};
              xtra = XTRA_JUMP;
            end
            OP_POINTER_CALL: begin
              ret_d = pc_q + 16'h0001;
              pc_d = {gpr_q[31], gpr_q[30]};
            end
            OP_EQUAL_SKIP, OP_SKIP_IF_REG_BIT_LOW, OP_SKIP_IF_REG_BIT_HIGH,
            OP_SKIP_IF_IO_BIT_LOW, OP_SKIP_IF_IO_BIT_HIGH: begin
              case (cmd.op)
                OP_EQUAL_SKIP: cond = (a == b);
                OP_SKIP_IF_REG_BIT_LOW: cond = ~b[cmd.bit_sel];
                OP_SKIP_IF_REG_BIT_HIGH: cond = b[cmd.bit_sel];
                OP_SKIP_IF_IO_BIT_LOW: cond = ~cmd.io_addr[5] &
                                              ~io_q[cmd.io_addr[4:0]][cmd.bit_sel];
                OP_SKIP_IF_IO_BIT_HIGH: cond = ~cmd.io_addr[5] &
                                               io_q[cmd.io_addr[4:0]][cmd.bit_sel];
                default: cond = 1'b0;
              endcase
              if (cond) begin
                pc_d = pc_q + 16'h0002 + {15'h0000, cmd.next_two_word};
                xtra = cmd.next_two_word ? XTRA_SKIP_TWO : XTRA_SKIP_ONE;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              if (!cmd.io_addr[5]) begin
                io_d[cmd.io_addr[4:0]][cmd.bit_sel] = (cmd.op == OP_IO_BIT_SET);
                xtra = XTRA_IO_BIT;
              end
            end
            OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW: begin
              cond = flg_q[cmd.bit_sel] == (cmd.op == OP_BRANCH_FLAG_HIGH);
              if (cond) begin
                pc_d = pc_q + 16'h0001 + {{9{cmd.disp[6]}}, cmd.disp};
                xtra = XTRA_BRANCH;
              end
            end
            default: xtra = XTRA_NONE;
          endcase
          if (cmd.op == OP_POINTER_CALL) begin
            st_d = ST_PUSH_LO;
          end else if (xtra == XTRA_NONE) begin
            done_d = 1'b1;
          end else begin
            st_d = ST_WAIT;
            cnt_d = xtra;
          end
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          st_d = ST_READY;
          done_d = 1'b1;
        end
      end
      ST_PUSH_LO: begin
        stk_we_d = 1'b1;
        stk_addr_d = sp_q;
        stk_data_d = ret_q[7:0];
        sp_d = sp_q - SP_W'(1);
        st_d = ST_PUSH_HI;
      end
      ST_PUSH_HI: begin
        stk_we_d = 1'b1;
        stk_addr_d = sp_q;
        stk_data_d = ret_q[15:8];
        sp_d = sp_q - SP_W'(1);
        st_d = ST_READY;
        done_d = 1'b1;
      end
      default: st_d = ST_READY;
    endcase
    ready_d = (st_d == ST_READY);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_READY;
      cnt_q <= XTRA_NONE;
      pc_q <= PC_RST;
      ret_q <= PC_RST;
      flg_q <= FLAGS_RST;
      sp_q <= SP_RST[SP_W-1:0];
      for (int i = 0; i < GPR_NUM; i++) begin
        gpr_q[i] <= GPR_RST;
      end
      for (int j = 0; j < IO_BIT_NUM; j++) begin
        io_q[j] <= GPR_RST;
      end
      ready_q <= 1'b1;
      done_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_addr_q <= '0;
      stk_data_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      ret_q <= ret_d;
      flg_q <= flg_d;
      sp_q <= sp_d;
      gpr_q <= gpr_d;
      io_q <= io_d;
      ready_q <= ready_d;
      done_q <= done_d;
      stk_we_q <= stk_we_d;
      stk_addr_q <= stk_addr_d;
      stk_data_q <= stk_data_d;
      rdata_q <= rdata_d;
    end
  end

  assign cmd_ready = ready_q;
  assign exec_done = done_q;
  assign pc = pc_q;
  assign cpu_flag_register = flg_q;
  assign stk_we = stk_we_q;
  assign stk_addr = stk_addr_q;
  assign stk_data = stk_data_q;
  assign bus_rdata = rdata_q;

endmodule

// ---- testbench/cab_exec_checker.sv ----
// checker: port timing and state relations of the execution unit
`timescale 1ns/10ps
module cab_exec_checker #(
  parameter int SP_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // command side
  input wire logic cmd_valid,
  input wire cab_pkg::cab_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic exec_done,
  // state and stack
  input wire logic [cab_pkg::PC_W-1:0] pc,
  input wire logic [7:0] cpu_flag_register,
  input wire logic stk_we,
  input wire logic [SP_W-1:0] stk_addr,
  input wire logic [7:0] stk_data
);
  import cab_pkg::*;
  logic tk;
  logic [15:0] tgt_d;
  logic [15:0] tgt_q;
  assign tk = cmd_valid && cmd_ready;
  // branch target as seen at the take edge
  always_comb begin
    tgt_d = pc + 16'h0001 + {{9{cmd.disp[6]}}, cmd.disp};
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgt_q <= 16'h0000;
    end else begin
      tgt_q <= tgt_d;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ----
  // sequences and properties
  // ----
  sequence s_two;
    !cmd_ready ##1 (exec_done && cmd_ready);
  endsequence
  sequence s_call;
    (!cmd_ready && !stk_we) ##1 (stk_we && !exec_done) ##1 (stk_we && exec_done && cmd_ready);
  endsequence
  property p_byte;
    tk && cmd.op inside {OP_SUM, OP_SUM_CARRY, OP_DIFF, OP_DIFFERENCE_IMM,
      OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_IMM_BORROW, OP_IMM_COMPARE}
      |=> exec_done && cmd_ready && $stable(cpu_flag_register[FLG_S]);
  endproperty
  property p_logic;
    tk && cmd.op inside {OP_CONJ, OP_CONJ_WITH_CONSTANT, OP_DISJ, OP_DISJ_WITH_CONSTANT,
      OP_EXCLUSIVE_DISJ, OP_MASK_SET, OP_MASK_CLEAR, OP_ZERO_NEG_CHECK}
      |=> exec_done && !cpu_flag_register[FLG_V] && $stable(cpu_flag_register[FLG_C])
      && $stable(cpu_flag_register[FLG_H]);
  endproperty
  property p_word;
    tk && cmd.op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM} |=> s_two;
  endproperty
  property p_jump;
    tk && cmd.op == OP_POINTER_JUMP |=> ($stable(cpu_flag_register) && !cmd_ready)
      ##1 (exec_done && $stable(cpu_flag_register));
  endproperty
  property p_call;
    tk && cmd.op == OP_POINTER_CALL |=> s_call;
  endproperty
  property p_ret;
    tk && cmd.op == OP_POINTER_CALL |-> ##2 (stk_data == $past(pc[7:0], 2) + 8'h01)
      ##1 (stk_addr == $past(stk_addr) - 1'b1);
  endproperty
  property p_br;
    tk && cmd.op == OP_BRANCH_FLAG_HIGH && cpu_flag_register[cmd.bit_sel]
      |=> (pc == tgt_q && !cmd_ready) ##1 exec_done;
  endproperty
  property p_nobr;
    tk && cmd.op == OP_BRANCH_FLAG_LOW && cpu_flag_register[cmd.bit_sel]
      |=> exec_done && pc == $past(pc) + 16'h0001;
  endproperty
  property p_io;
    tk && cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} && cmd.io_addr < 6'h20 |=> s_two;
  endproperty
  property p_io_far;
    tk && cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_LOW,
      OP_SKIP_IF_IO_BIT_HIGH} && cmd.io_addr >= 6'h20 |=> exec_done && pc == $past(pc) + 16'h0001;
  endproperty
  a_byte: assert property (p_byte) else $error("byte op timing or S");
  a_logic: assert property (p_logic) else $error("logic op flags");
  a_word: assert property (p_word) else $error("word op timing");
  a_jump: assert property (p_jump) else $error("jump timing or flags");
  a_call: assert property (p_call) else $error("call timing");
  a_ret: assert property (p_ret) else $error("call push");
  a_br: assert property (p_br) else $error("taken branch");
  a_nobr: assert property (p_nobr) else $error("branch not taken");
  a_io: assert property (p_io) else $error("io bit timing");
  a_io_far: assert property (p_io_far) else $error("high io bit op");
endmodule

bind cab_exec cab_exec_checker #(.SP_W(SP_W)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .exec_done(exec_done), .pc(pc),
  .cpu_flag_register(cpu_flag_register), .stk_we(stk_we), .stk_addr(stk_addr),
  .stk_data(stk_data));

// ---- testbench/cab_exec_test.sv ----
// testbench: execution unit driven over its command and register ports
`timescale 1ns/10ps
module cab_exec_test;
  import cab_pkg::*;
  typedef struct {cab_op_t op; logic [7:0] a, b, k, fi, r, fo;} cab_alu_t;
  typedef struct {cab_op_t op; logic [4:0] s; logic [2:0] b; logic [5:0] io; logic two;
    int n;} cab_skp_t;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  cab_cmd_t cmd = '0;
  cab_cmd_t c;
  logic cmd_ready, exec_done, stk_we;
  logic [15:0] pc, xpc;
  logic [7:0] cpu_flag_register, stk_addr, stk_data, bus_rdata;
  logic [15:0] stk_q [$];
  int num_errors = 0;
  int samples_checked = 0;
  cab_alu_t alu [16] = '{
    '{OP_SUM, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h10, 8'h20},
    '{OP_SUM_CARRY, 8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h23},
    '{OP_DIFF, 8'h80, 8'h01, 8'h00, 8'h00, 8'h7f, 8'h28},
    '{OP_DIFFERENCE_IMM, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02},
    '{OP_DIFFERENCE_WITH_BORROW, 8'h00, 8'h00, 8'h00, 8'h03, 8'hff, 8'h25},
    '{OP_DIFFERENCE_IMM_BORROW, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h02},
    '{OP_DIFFERENCE_IMM_BORROW, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00},
    '{OP_CONJ, 8'hf0, 8'h8f, 8'h00, 8'h29, 8'h80, 8'h25},
    '{OP_CONJ_WITH_CONSTANT, 8'h0f, 8'hff, 8'hf0, 8'h08, 8'h00, 8'h02},
    '{OP_DISJ, 8'h40, 8'h80, 8'h00, 8'h00, 8'hc0, 8'h04},
    '{OP_DISJ_WITH_CONSTANT, 8'h01, 8'h00, 8'h02, 8'h02, 8'h03, 8'h00},
    '{OP_EXCLUSIVE_DISJ, 8'haa, 8'haa, 8'h00, 8'h04, 8'h00, 8'h02},
    '{OP_MASK_SET, 8'h00, 8'h00, 8'h81, 8'h00, 8'h81, 8'h04},
    '{OP_MASK_CLEAR, 8'hff, 8'h00, 8'h0f, 8'h00, 8'hf0, 8'h04},
    '{OP_ZERO_NEG_CHECK, 8'h00, 8'hff, 8'h00, 8'h0c, 8'h00, 8'h02},
    '{OP_IMM_COMPARE, 8'h05, 8'h00, 8'h06, 8'h00, 8'h05, 8'h25}};
  cab_skp_t skp [11] = '{
    '{OP_EQUAL_SKIP, 5'h02, 3'h0, 6'h00, 1'b0, 2},
    '{OP_EQUAL_SKIP, 5'h02, 3'h0, 6'h00, 1'b1, 3},
    '{OP_EQUAL_SKIP, 5'h03, 3'h0, 6'h00, 1'b1, 1},
    '{OP_SKIP_IF_REG_BIT_LOW, 5'h02, 3'h0, 6'h00, 1'b1, 3},
    '{OP_SKIP_IF_REG_BIT_LOW, 5'h02, 3'h1, 6'h00, 1'b0, 1},
    '{OP_SKIP_IF_REG_BIT_HIGH, 5'h02, 3'h6, 6'h00, 1'b0, 2},
    '{OP_SKIP_IF_REG_BIT_HIGH, 5'h02, 3'h2, 6'h00, 1'b1, 1},
    '{OP_SKIP_IF_IO_BIT_HIGH, 5'h00, 3'h1, 6'h1f, 1'b0, 2},
    '{OP_SKIP_IF_IO_BIT_LOW, 5'h00, 3'h2, 6'h1f, 1'b1, 3},
    '{OP_SKIP_IF_IO_BIT_HIGH, 5'h00, 3'h0, 6'h3f, 1'b0, 1},
    '{OP_SKIP_IF_IO_BIT_LOW, 5'h00, 3'h7, 6'h20, 1'b0, 1}};

  cab_exec uut (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .exec_done(exec_done), .pc(pc),
    .cpu_flag_register(cpu_flag_register), .stk_we(stk_we), .stk_addr(stk_addr),
    .stk_data(stk_data), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // stack pushes, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (stk_we === 1'b1) begin
      stk_q.push_back({stk_addr, stk_data});
    end
  end
  // ----
  // tasks
  // ----
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk({8'h00, bus_rdata}, {8'h00, e});
  endtask
  task automatic pcchk(input logic [15:0] e);
    rd(ADR_PC_LO, e[7:0]);
    rd(ADR_PC_HI, e[15:8]);
  endtask
  // issue one command and count cycles up to exec_done
  task automatic run(input cab_cmd_t x, input int n);
    int k;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= x;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    k = 1;
    while (exec_done !== 1'b1) begin
      if (k > 6) begin
        num_errors++;
        stop_test();
      end
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk(16'(k), 16'(n));
  endtask
  function automatic cab_cmd_t mk(cab_op_t o, logic [4:0] d = 5'h00, logic [4:0] s = 5'h00,
      logic [7:0] k = 8'h00);
    mk = '0;
    mk.op = o;
    mk.dst = d;
    mk.src = s;
    mk.imm = k;
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADR_FLAGS, FLAGS_RST);
    rd(ADR_SP, 8'hff);
    wr(8'h80, 8'h5a);
    rd(8'h80, 8'h00);
    wr(ADR_PC_LO, 8'h55);
    rd(ADR_PC_LO, 8'h00);
    $display("test reset and map done");
    foreach (alu[i]) begin
      wr(8'h10, alu[i].a);
      wr(8'h11, alu[i].b);
      wr(ADR_FLAGS, alu[i].fi);
      run(mk(alu[i].op, 5'h10, 5'h11, alu[i].k), 1);
      rd(8'h10, alu[i].r);
      rd(ADR_FLAGS, alu[i].fo);
    end
    $display("test byte ops done");
    wr(8'h18, 8'hff);
    wr(ADR_FLAGS, 8'h00);
    run(mk(OP_WORD_PLUS_IMM, 5'h00, 5'h00, 8'h01), 2);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    rd(ADR_FLAGS, 8'h00);
    c = mk(OP_WORD_MINUS_IMM, 5'h00, 5'h00, 8'h01);
    c.pair_sel = 2'h1;
    run(c, 2);
    rd(8'h1b, 8'hff);
    rd(ADR_FLAGS, 8'h15);
    $display("test word ops done");
    wr(8'h1e, 8'h34);
    wr(8'h1f, 8'h12);
    wr(ADR_FLAGS, 8'h3f);
    run(mk(OP_POINTER_JUMP), 2);
    pcchk(16'h1234);
    rd(ADR_FLAGS, 8'h3f);
    wr(8'h1f, 8'h01);
    run(mk(OP_POINTER_CALL), 3);
    pcchk(16'h0134);
    rd(ADR_SP, 8'hfd);
    chk(stk_q[0], 16'hff35);
    chk(stk_q[1], 16'hfe12);
    $display("test jump and call done");
    xpc = 16'h0134;
    for (int s = 0; s < 8; s++) begin
      wr(ADR_FLAGS, 8'h01 << s);
      c = mk(OP_BRANCH_FLAG_HIGH);
      c.bit_sel = 3'(s);
      c.disp = 7'h7e;
      run(c, 2);
      pcchk(xpc - 16'h0001);
      c.op = OP_BRANCH_FLAG_LOW;
      run(c, 1);
      pcchk(xpc);
    end
    c.bit_sel = 3'h0;
    c.disp = 7'h3f;
    run(c, 2);
    xpc = xpc + 16'h0040;
    pcchk(xpc);
    $display("test branches done");
    wr(8'h3f, 8'h81);
    c = mk(OP_IO_BIT_SET);
    c.io_addr = 6'h1f;
    c.bit_sel = 3'h1;
    run(c, 2);
    rd(8'h3f, 8'h83);
    c.op = OP_IO_BIT_CLEAR;
    c.bit_sel = 3'h7;
    run(c, 2);
    rd(8'h3f, 8'h03);
    c.op = OP_IO_BIT_SET;
    c.io_addr = 6'h20;
    run(c, 1);
    rd(8'h20, 8'h00);
    xpc = xpc + 16'h0003;
    pcchk(xpc);
    $display("test io bits done");
    wr(8'h01, 8'h5a);
    wr(8'h02, 8'h5a);
    foreach (skp[i]) begin
      c = mk(skp[i].op, 5'h01, skp[i].s);
      c.bit_sel = skp[i].b;
      c.io_addr = skp[i].io;
      c.next_two_word = skp[i].two;
      run(c, skp[i].n);
      xpc = xpc + 16'(skp[i].n);
      pcchk(xpc);
    end
    run(mk(OP_IDLE), 1);
    xpc = xpc + 16'h0001;
    pcchk(xpc);
    rd(ADR_FLAGS, 8'h80);
    $display("test skips done");
    stop_test();
  end
endmodule
